// ===== hdl/srap_regs.vh
// Register offsets, reset values and frame constants of the serial register-access port
`ifndef SRAP_REGS_VH
`define SRAP_REGS_VH
// ==========================================================
// Frame layout
`define SRAP_FRAME_BITS 5'd24
`define SRAP_HDR_BITS 5'd16
`define SRAP_ADDR_W 15
// ==========================================================
// Byte addresses
`define SRAP_A_CFG_A 15'h0000
`define SRAP_A_DEV_CFG 15'h0002
`define SRAP_A_PART_TYPE 15'h0003
`define SRAP_A_PART_ID_L 15'h0004
`define SRAP_A_PART_ID_H 15'h0005
`define SRAP_A_PART_REV 15'h0006
`define SRAP_A_MAKER_L 15'h000c
`define SRAP_A_MAKER_H 15'h000d
`define SRAP_A_USER_CFG 15'h0010
`define SRAP_A_CLOCK_CONTROL_0 15'h0029
`define SRAP_A_CLOCK_CONTROL_1 15'h002a
`define SRAP_A_SYSREF_0 15'h002c
`define SRAP_A_SYSREF_1 15'h002d
`define SRAP_A_SYSREF_2 15'h002e
`define SRAP_A_FSR_A_L 15'h0030
`define SRAP_A_FSR_A_H 15'h0031
`define SRAP_A_FSR_B_L 15'h0032
`define SRAP_A_FSR_B_H 15'h0033
`define SRAP_A_REF_BYP 15'h0038
`define SRAP_A_TMSTP 15'h003b
`define SRAP_A_SERIALIZER_PREEMPHASIS 15'h0048
`define SRAP_A_IN_MUX 15'h0060
`define SRAP_A_CAL_EN 15'h0061
`define SRAP_A_CALIBRATION_CONFIG_0 15'h0062
`define SRAP_A_CAL_STATE 15'h006a
// ==========================================================
// Reset values
`define SRAP_R_CFG_A 8'h30
`define SRAP_R_ZERO 8'h00
`define SRAP_R_CLOCK_CONTROL_1 8'h20
`define SRAP_R_FSR 16'ha000
`define SRAP_R_ONE 8'h01
// ==========================================================
// Field positions
`define SRAP_ASC_BIT_HI 5
`define SRAP_ASC_BIT_LO 2
`define SRAP_HOLD_BIT 0
`endif

// ===== hdl/srap_sync.v
// Three-stage synchroniser with agreement filter for one pin input
`timescale 1ns/1ps
module srap_sync #(
  parameter INIT = 1'b0
) (
  input wire clk_in,
  input wire reset_in,
  input wire pin_in,
  output reg level_out
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  // ==========================================================
  // Sampling chain; first stage feeds only the second
  always @(posedge clk_in) begin
    if (reset_in) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      level_out <= INIT;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // Change counts only once stages two and three agree
      if (s2_reg == s3_reg) begin
        level_out <= s3_reg;
      end
    end
  end
endmodule // srap_sync

// ===== hdl/srap_port.v
// Serial register-access port: frame decoder, register map and streaming
`timescale 1ns/1ps
`include "srap_regs.vh"
// What this block does
// - Each access is a 24-bit frame: direction bit, address, one data byte.
// - Fifteen bits after the direction bit give the register address.
// - Write frame stores the last eight input bits into the addressed register.
// - Read frame ignores last eight input bits and shifts register out.
// - All fields travel most significant bit first.
// - Multi-byte registers are little-endian, low byte at lowest address.
// - Output stays undriven in write frames and the read header.
// - Streaming: more bytes follow while select stays low.
// - Address steps by one per extra byte, up by default, down if both ascend bits are cleared.
// - Ascend setting sits at bits 5 and 2 of address zero.
// - Address-hold bit in user serial config disables address stepping.
// - Both full-scale range registers are 16-bit, reset to 0xa000.
// - User serial config resets to zero; rest of its group read-only.
// - Sysref capture position is read-only over three byte addresses.
// - Select is active low; access only while held low.
// - Input sampled on rising serial clock; no minimum clock rate.
// ==========================================================
// Operating notes
// The serial clock is not a clock here. It is sampled like any other pin,
// and its edges are found in the system clock domain. The system clock must
// therefore run well above the serial clock rate. Each serial clock phase
// must last at least two system clock periods, or edges are lost.
// Select, serial clock and serial data all pass the same three-stage chain.
// They stay aligned with each other after synchronisation, so the data bit
// seen at a detected rising edge is the one the host set up before that edge.
// A frame is counted in two parts. The header holds the direction bit and
// fifteen address bits. The data part holds bytes, and the first byte closes
// the minimum frame. Further bytes while select stays low are streaming bytes.
// Each byte is written into its register only when its eighth bit arrives.
// A frame or a streaming byte cut short by select rising leaves every
// register untouched. The host may then abandon a transfer at any bit.
// Read data are fetched once per byte, at the rising edge that completes
// the header or the previous byte. A read-only input that changes
// inside a byte does not tear that byte on the wire.
// The output enable follows the direction bit of the current frame only.
// It rises at the first falling edge after the header and falls when select
// is seen high, some five system clocks after the pin rises.
// Multi-byte registers are written one byte at a time. A host that updates
// both bytes of a range register sees one intermediate value between them.
// While the address ascends, a burst write that starts at the low byte keeps that window shortest.
// Register traffic during calibration is the host's concern. This block does
// not block it, since calibration state is only an input shown for reading.
module srap_port #(
  parameter [7:0] PART_TYPE = 8'h5a, // Arbitrary identity value
  parameter [15:0] PART_ID = 16'h1234, // Arbitrary identity value
  parameter [7:0] PART_REV = 8'h01, // Arbitrary identity value
  parameter [15:0] MAKER_ID = 16'h7e7e // Arbitrary identity value
) (
  input wire clk_in,
  input wire reset_in,
  input wire select_n_pin_in,
  input wire sclk_pin_in,
  input wire serial_in_pin_in,
  input wire [23:0] sysref_capture_position_in,
  input wire [7:0] calibration_state_in,
  output reg serial_out_pin_out,
  output reg serial_out_pin_oe_out,
  output reg [7:0] user_serial_config_out,
  output reg [15:0] input_a_fullscale_range_out,
  output reg [15:0] input_b_fullscale_range_out,
  output reg [7:0] calibration_enable_out
);
  // ==========================================================
  // Pin synchronisers
  wire sel_n;
  wire sclk;
  wire serial_in_pin;
  // Select resets to its idle level so no false frame start follows reset
  srap_sync #(.INIT(1'b1)) u_sel (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .pin_in(select_n_pin_in),
    .level_out(sel_n)
  );
  // Serial clock resets to its parked level so no false edge follows reset
  srap_sync #(.INIT(1'b0)) u_clk (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .pin_in(sclk_pin_in),
    .level_out(sclk)
  );
  // Same depth as the clock chain keeps data aligned to its edge
  srap_sync #(.INIT(1'b0)) u_sdi (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .pin_in(serial_in_pin_in),
    .level_out(serial_in_pin)
  );
  // Edge detection on the filtered serial clock
  reg sclk_d_reg;
  wire rise = sclk & ~sclk_d_reg;
  wire fall = ~sclk & sclk_d_reg;
  // ==========================================================
  // Register storage
  // Only registers that other logic would use leave the block as outputs.
  // The rest are kept here for read-back, so the host sees what it wrote.
  // Reserved addresses have no storage at all; they read as zero.
  reg [7:0] cfg_a_reg;
  reg [7:0] dev_cfg_reg;
  reg [7:0] clock_control_0_reg;
  reg [7:0] clock_control_1_reg;
  reg [7:0] ref_byp_reg;
  reg [7:0] tmstp_reg;
  reg [7:0] serializer_preemphasis_reg;
  reg [7:0] in_mux_reg;
  reg [7:0] calibration_config_0_reg;
  // ==========================================================
  // Frame state
  reg [4:0] cnt_reg;
  reg [14:0] addr_reg;
  reg [7:0] shift_reg;
  reg [7:0] out_reg;
  reg rd_reg;
  reg hdr_done_reg;
  reg out_en_reg;
  wire ascend = cfg_a_reg[`SRAP_ASC_BIT_HI] | cfg_a_reg[`SRAP_ASC_BIT_LO];
  wire hold = user_serial_config_out[`SRAP_HOLD_BIT];
  // Read decode, shared by the first byte and streaming bytes
  function [7:0] rd_mux;
    input [14:0] a;
    begin
      case (a)
        `SRAP_A_CFG_A: rd_mux = cfg_a_reg;
        `SRAP_A_DEV_CFG: rd_mux = dev_cfg_reg;
        `SRAP_A_PART_TYPE: rd_mux = PART_TYPE;
        `SRAP_A_PART_ID_L: rd_mux = PART_ID[7:0];
        `SRAP_A_PART_ID_H: rd_mux = PART_ID[15:8];
        `SRAP_A_PART_REV: rd_mux = PART_REV;
        `SRAP_A_MAKER_L: rd_mux = MAKER_ID[7:0];
        `SRAP_A_MAKER_H: rd_mux = MAKER_ID[15:8];
        `SRAP_A_USER_CFG: rd_mux = user_serial_config_out;
        `SRAP_A_CLOCK_CONTROL_0: rd_mux = clock_control_0_reg;
        `SRAP_A_CLOCK_CONTROL_1: rd_mux = clock_control_1_reg;
        `SRAP_A_SYSREF_0: rd_mux = sysref_capture_position_in[7:0];
        `SRAP_A_SYSREF_1: rd_mux = sysref_capture_position_in[15:8];
        `SRAP_A_SYSREF_2: rd_mux = sysref_capture_position_in[23:16];
        `SRAP_A_FSR_A_L: rd_mux = input_a_fullscale_range_out[7:0];
        `SRAP_A_FSR_A_H: rd_mux = input_a_fullscale_range_out[15:8];
        `SRAP_A_FSR_B_L: rd_mux = input_b_fullscale_range_out[7:0];
        `SRAP_A_FSR_B_H: rd_mux = input_b_fullscale_range_out[15:8];
        `SRAP_A_REF_BYP: rd_mux = ref_byp_reg;
        `SRAP_A_TMSTP: rd_mux = tmstp_reg;
        `SRAP_A_SERIALIZER_PREEMPHASIS: rd_mux = serializer_preemphasis_reg;
        `SRAP_A_IN_MUX: rd_mux = in_mux_reg;
        `SRAP_A_CAL_EN: rd_mux = calibration_enable_out;
        `SRAP_A_CALIBRATION_CONFIG_0: rd_mux = calibration_config_0_reg;
        `SRAP_A_CAL_STATE: rd_mux = calibration_state_in;
        // Reserved and unmapped addresses read as zero
        default: rd_mux = 8'h00;
      endcase
    end
  endfunction
  function [14:0] next_addr;
    input [14:0] a;
    input up;
    input hld;
    begin
      if (hld) begin
        next_addr = a;
      end else if (up) begin
        next_addr = a + 15'h0001;
      end else begin
        next_addr = a - 15'h0001;
      end
    end
  endfunction
  wire [7:0] byte_in = {shift_reg[6:0], serial_in_pin};
  // ==========================================================
  // Frame decoder and register writes
  // Counter use: during the header it counts bits 0 to 15; after the header
  // it counts bits 0 to 7 of each data byte and wraps for streaming.
  // The address shifts in from the second header bit on, so after sixteen
  // bits it holds exactly the fifteen address bits.
  // Deselect clears the counter and the header flag at once. A partial byte
  // never reaches the write decode, which needs the eighth bit.
  // The address steps after every byte, read or write, unless address hold is set, so a streaming read
  // fetches the next byte before its first bit is due on the wire.
  always @(posedge clk_in) begin
    if (reset_in) begin
      sclk_d_reg <= 1'b0;
      cnt_reg <= 5'd0;
      addr_reg <= 15'h0000;
      shift_reg <= 8'h00;
      out_reg <= 8'h00;
      rd_reg <= 1'b0;
      hdr_done_reg <= 1'b0;
      out_en_reg <= 1'b0;
      serial_out_pin_out <= 1'b0;
      serial_out_pin_oe_out <= 1'b0;
      cfg_a_reg <= `SRAP_R_CFG_A;
      dev_cfg_reg <= `SRAP_R_ZERO;
      user_serial_config_out <= `SRAP_R_ZERO;
      clock_control_0_reg <= `SRAP_R_ZERO;
      clock_control_1_reg <= `SRAP_R_CLOCK_CONTROL_1;
      input_a_fullscale_range_out <= `SRAP_R_FSR;
      input_b_fullscale_range_out <= `SRAP_R_FSR;
      ref_byp_reg <= `SRAP_R_ZERO;
      tmstp_reg <= `SRAP_R_ZERO;
      serializer_preemphasis_reg <= `SRAP_R_ZERO;
      in_mux_reg <= `SRAP_R_ONE;
      calibration_enable_out <= `SRAP_R_ONE;
      calibration_config_0_reg <= `SRAP_R_ZERO;
    end else begin
      sclk_d_reg <= sclk;
      if (sel_n) begin
        cnt_reg <= 5'd0;
        hdr_done_reg <= 1'b0;
        out_en_reg <= 1'b0;
        serial_out_pin_oe_out <= 1'b0;
      end else begin
        if (rise) begin
          shift_reg <= byte_in;
          if (!hdr_done_reg) begin
            cnt_reg <= cnt_reg + 5'd1;
            if (cnt_reg == 5'd0) begin
              rd_reg <= serial_in_pin;
            end else begin
              addr_reg <= {addr_reg[13:0], serial_in_pin};
            end
            if (cnt_reg == `SRAP_HDR_BITS - 5'd1) begin
              hdr_done_reg <= 1'b1;
              cnt_reg <= 5'd0;
              out_reg <= rd_mux({addr_reg[13:0], serial_in_pin});
              out_en_reg <= rd_reg;
            end
          end else begin
            cnt_reg <= (cnt_reg == 5'd7) ? 5'd0 : cnt_reg + 5'd1;
            if (cnt_reg == 5'd7) begin
              if (!rd_reg) begin
                case (addr_reg)
                  `SRAP_A_CFG_A: cfg_a_reg <= byte_in;
                  `SRAP_A_DEV_CFG: dev_cfg_reg <= byte_in;
                  `SRAP_A_USER_CFG: user_serial_config_out <= byte_in;
                  `SRAP_A_CLOCK_CONTROL_0: clock_control_0_reg <= byte_in;
                  `SRAP_A_CLOCK_CONTROL_1: clock_control_1_reg <= byte_in;
                  `SRAP_A_FSR_A_L: input_a_fullscale_range_out[7:0] <= byte_in;
                  `SRAP_A_FSR_A_H: input_a_fullscale_range_out[15:8] <= byte_in;
                  `SRAP_A_FSR_B_L: input_b_fullscale_range_out[7:0] <= byte_in;
                  `SRAP_A_FSR_B_H: input_b_fullscale_range_out[15:8] <= byte_in;
                  `SRAP_A_REF_BYP: ref_byp_reg <= byte_in;
                  `SRAP_A_TMSTP: tmstp_reg <= byte_in;
                  `SRAP_A_SERIALIZER_PREEMPHASIS: serializer_preemphasis_reg <= byte_in;
                  `SRAP_A_IN_MUX: in_mux_reg <= byte_in;
                  `SRAP_A_CAL_EN: calibration_enable_out <= byte_in;
                  `SRAP_A_CALIBRATION_CONFIG_0: calibration_config_0_reg <= byte_in;
                  // Read-only and reserved addresses ignore writes
                  default: ;
                endcase
              end
              addr_reg <= next_addr(addr_reg, ascend, hold);
              out_reg <= rd_mux(next_addr(addr_reg, ascend, hold));
            end else begin
              // Shift next read bit into place for the coming falling edge
              out_reg <= {out_reg[6:0], 1'b0};
            end
          end
        end
        // The host samples read bits on its rising edge. Driving on the
        // falling edge gives half a serial clock period of margin, less the
        // synchroniser delay of about five system clocks.
        // In a write frame the enable stays low, because out_en_reg holds
        // the direction bit, which is low for writes.
        // drive on fall
        if (fall && hdr_done_reg) begin
          serial_out_pin_oe_out <= out_en_reg;
          serial_out_pin_out <= out_reg[7];
        end
      end
    end
  end
endmodule // srap_port

// ===== tb/srap_port_asserts.sv
// Assertion checker for the serial register-access port
`timescale 1ns/1ps
module srap_port_asserts (
  input wire clk_in,
  input wire reset_in,
  input wire select_n_pin_in,
  input wire sclk_pin_in,
  input wire serial_in_pin_in,
  input wire serial_out_pin_out,
  input wire serial_out_pin_oe_out,
  input wire [7:0] user_serial_config_out,
  input wire [15:0] input_a_fullscale_range_out,
  input wire [15:0] input_b_fullscale_range_out
);
  // ====
  // Frame trackers on raw pins, so they lead the port's synchronisers
  reg sclk_q;
  reg rd_flag;
  reg [7:0] rises;
  reg [3:0] hi_cnt;
  reg [3:0] fall_age;
  wire rise_seen = sclk_pin_in & ~sclk_q;
  always @(posedge clk_in) begin
    sclk_q <= sclk_pin_in;
    if (reset_in) begin
      hi_cnt <= 4'hf;
      fall_age <= 4'hf;
      rises <= 8'h00;
      rd_flag <= 1'b0;
    end else begin
      hi_cnt <= select_n_pin_in ? hi_cnt + {3'h0, hi_cnt != 4'hf} : 4'h0;
      fall_age <= (sclk_q & ~sclk_pin_in) ? 4'h0 : fall_age + {3'h0, fall_age != 4'hf};
      rises <= select_n_pin_in ? 8'h00 : rises + {7'h0, rise_seen};
      if (rise_seen && rises == 8'h00)
        rd_flag <= serial_in_pin_in;
    end
  end
  // ====
  // Checks
  default clocking dc @(posedge clk_in); endclocking
  default disable iff (reset_in);
  a_reset_values: assert property ($fell(reset_in) |-> user_serial_config_out == 8'h00 &&
    input_a_fullscale_range_out == 16'ha000 && input_b_fullscale_range_out == 16'ha000)
    else $error("registers not at reset values");
  a_oe_read_only: assert property (serial_out_pin_oe_out |-> rd_flag)
    else $error("output driven outside a read");
  a_oe_start: assert property ($rose(serial_out_pin_oe_out) |-> rises == 8'h10)
    else $error("output enabled at wrong bit");
  a_oe_idle: assert property (hi_cnt >= 4'h8 |-> !serial_out_pin_oe_out)
    else $error("output driven while deselected");
  a_oe_holds: assert property ($fell(serial_out_pin_oe_out) |-> hi_cnt != 4'h0)
    else $error("output released inside frame");
  a_out_on_fall: assert property (serial_out_pin_oe_out && $past(serial_out_pin_oe_out) &&
    $changed(serial_out_pin_out) |-> fall_age <= 4'h7) else $error("output bit moved off falling edge");
  a_write_moment: assert property (!$stable(user_serial_config_out) || !$stable(input_a_fullscale_range_out) ||
    !$stable(input_b_fullscale_range_out) |-> !rd_flag && rises >= 8'h18 && rises[2:0] == 3'h0)
    else $error("register changed outside a whole write byte");
  a_idle_stable: assert property (hi_cnt == 4'hf |=> $stable(input_a_fullscale_range_out) &&
    $stable(input_b_fullscale_range_out) && $stable(user_serial_config_out)) else $error("register moved while idle");
  c_read: cover property ($rose(serial_out_pin_oe_out));
  c_burst: cover property (rises == 8'h20);
  c_short: cover property ($rose(select_n_pin_in) && rises == 8'h14);
endmodule // srap_port_asserts

// ===== tb/srap_host.sv
// Host controller model driving frames on the four-wire serial bus
`timescale 1ns/1ps
module srap_host (
  output logic select_n_out,
  output logic sclk_out,
  output logic sdi_out,
  input wire sdo_in
);
  // Idle bus: deselected, clock parked low
  initial begin
    select_n_out = 1'b1;
    sclk_out = 1'b0;
    sdi_out = 1'b0;
  end
  // ====
  // direction, address, data, MSB first
  // select low throughout, data steady over rising edge
  // the bench never runs calibration, so traffic is always allowed
  task automatic xfer(input logic rd, input logic [14:0] a, input int ntot, input logic [31:0] wd,
    output logic [31:0] rdat);
    logic [47:0] v;
    v = {rd, a, wd};
    rdat = 32'h0;
    select_n_out = 1'b0;
    for (int i = 0; i < ntot; i++) begin
      sdi_out = v[47 - i];
      #62.5;
      sclk_out = 1'b1;
      if (i >= 16)
        rdat = {rdat[30:0], sdo_in};
      #62.5;
      sclk_out = 1'b0;
    end
    #62.5;
    select_n_out = 1'b1;
    sdi_out = ~sdi_out; // Released line shows no stale bit
    #250;
  endtask
endmodule // srap_host

// ===== tb/tb.sv
// Self-checking bench for the serial register-access port
`timescale 1ns/1ps
module tb;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  wire sel_n, sclk, serial_in_pin, sdo_line, sdo_bit, sdo_oe;
  wire [7:0] user_cfg, cal_en;
  wire [15:0] fsr_a, fsr_b;
  logic [31:0] rdat;
  int err_total = 0;
  int checked = 0;
  int cycles = 0;
  logic [7:0] asc [0:1] = '{8'h20, 8'h04};
  // Address, byte written, byte read back
  logic [30:0] rows [0:9] = '{{15'h0030, 8'h12, 8'h12}, {15'h0031, 8'h5c, 8'h5c}, {15'h0029, 8'ha5, 8'ha5},
    {15'h0003, 8'hff, 8'h3c}, {15'h0011, 8'hff, 8'h00}, {15'h002c, 8'hff, 8'hef}, {15'h002e, 8'hff, 8'hab},
    {15'h006a, 8'hff, 8'h96}, {15'h7fff, 8'hff, 8'h00}, {15'h0061, 8'h3b, 8'h3b}};
  always #5 clk_in = ~clk_in;
  // Undriven serial output shows the inverse, never a stale bit
  assign sdo_line = sdo_oe ? sdo_bit : ~sdo_bit;
  srap_host i_host (.select_n_out(sel_n), .sclk_out(sclk), .sdi_out(serial_in_pin), .sdo_in(sdo_line));
  srap_port #(.PART_TYPE(8'h3c)) i_dut (.clk_in(clk_in), .reset_in(reset_in), .select_n_pin_in(sel_n),
    .sclk_pin_in(sclk), .serial_in_pin_in(serial_in_pin), .sysref_capture_position_in(24'habcdef),
    .calibration_state_in(8'h96), .serial_out_pin_out(sdo_bit), .serial_out_pin_oe_out(sdo_oe),
    .user_serial_config_out(user_cfg), .input_a_fullscale_range_out(fsr_a),
    .input_b_fullscale_range_out(fsr_b), .calibration_enable_out(cal_en));
  // ====
  // Compare, report and close
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (err_total == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Hang guard, about two and a half times the expected run
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic do_reset();
    #1 reset_in = 1'b1;
    repeat (6) @(posedge clk_in);
    #1 reset_in = 1'b0;
    repeat (5) @(posedge clk_in);
  endtask
  // ====
  // Main sequence
  initial begin
    do_reset();
    for (int i = 0; i < 10; i++) begin
      i_host.xfer(1'b0, rows[i][30:16], 24, {rows[i][15:8], 24'h0}, rdat);
      i_host.xfer(1'b1, rows[i][30:16], 24, 32'h0, rdat);
      chk("row readback", rdat[15:0], {8'h00, rows[i][7:0]});
    end
    chk("fsr a bytes", fsr_a, 16'h5c12);
    chk("cal enable", {8'h00, cal_en}, 16'h003b);
    i_host.xfer(1'b0, 15'h0032, 20, 32'hffffffff, rdat);
    chk("short frame", fsr_b, 16'ha000);
    i_host.xfer(1'b0, 15'h0032, 32, 32'h34120000, rdat);
    chk("burst write", fsr_b, 16'h1234);
    i_host.xfer(1'b1, 15'h0032, 32, 32'h0, rdat);
    chk("burst read", rdat[15:0], 16'h3412);
    foreach (asc[k]) begin
      i_host.xfer(1'b0, 15'h0000, 24, {asc[k], 24'h0}, rdat);
      i_host.xfer(1'b0, 15'h0029, 32, {8'h00, asc[k], 16'h0}, rdat);
      i_host.xfer(1'b1, 15'h002a, 24, 32'h0, rdat);
      chk("ascend bit", rdat[15:0], {8'h00, asc[k]});
    end
    i_host.xfer(1'b0, 15'h0000, 24, 32'h0, rdat);
    i_host.xfer(1'b0, 15'h0031, 32, 32'h77660000, rdat);
    chk("descend", fsr_a, 16'h7766);
    i_host.xfer(1'b0, 15'h0010, 24, 32'h01000000, rdat);
    i_host.xfer(1'b0, 15'h0061, 32, 32'h11220000, rdat);
    chk("address hold", {user_cfg, cal_en}, 16'h0122);
    do_reset();
    chk("reset fsr a", fsr_a, 16'ha000);
    chk("reset fsr b", fsr_b, 16'ha000);
    chk("reset cfg", {user_cfg, cal_en}, 16'h0001);
    i_host.xfer(1'b1, 15'h0000, 24, 32'h0, rdat);
    chk("reset 000", rdat[15:0], 16'h0030);
    i_host.xfer(1'b1, 15'h0029, 32, 32'h0, rdat);
    chk("reset 029", rdat[15:0], 16'h0020);
    give_verdict();
  end
endmodule // tb
bind srap_port srap_port_asserts i_chk (.clk_in(clk_in), .reset_in(reset_in), .select_n_pin_in(select_n_pin_in),
  .sclk_pin_in(sclk_pin_in), .serial_in_pin_in(serial_in_pin_in), .serial_out_pin_out(serial_out_pin_out),
  .serial_out_pin_oe_out(serial_out_pin_oe_out), .user_serial_config_out(user_serial_config_out),
  .input_a_fullscale_range_out(input_a_fullscale_range_out),
  .input_b_fullscale_range_out(input_b_fullscale_range_out));
